// ---- core/lacp_regs.vh ----
// Purpose: Constants for the login access control policy block
// Assumes: 10 MHz system clock, 1 ms timer tick
// Notes:   Offsets are byte addresses on the plain register port
`ifndef LACP_REGS_VH
`define LACP_REGS_VH

// Clock and tick
`define LACP_CLK_HZ        10000000
`define LACP_TICK_US       1000
`define LACP_TICK_CYC      14'h2710

// Register offsets
`define LACP_REG_CTRL      8'h00
`define LACP_REG_PAYI2T    8'h04
`define LACP_REG_PAYT2I    8'h08
`define LACP_REG_STATUS    8'h0C
`define LACP_REG_OWNLO     8'h10
`define LACP_REG_OWNHI     8'h14
`define LACP_REG_KEY       8'h18
`define LACP_REG_NEG       8'h1C
`define LACP_REG_NEGPAY    8'h20

// Field positions
`define LACP_CTRL_RES_LSB  0
`define LACP_CTRL_ALV_LSB  4
`define LACP_NEGPAY_T2I    16

// Reset values
`define LACP_RST_APPRES    3'h7
`define LACP_RST_APPALV    3'h7
`define LACP_RST_PAYMAX    14'h2000
`define LACP_NO_OWNER      64'hFFFFFFFFFFFFFFFF
`define LACP_KEY_SEED      32'h00000001
`define LACP_LFSR_TAPS     32'h80200003

// Payload limit in 128-byte units (2^20 bytes)
`define LACP_PAY_LIMIT     14'h2000

// Owner clear delay after release, in ms
`define LACP_CLEAR_MS      19'h003E8

// Alive timeout table, in ms
`define LACP_ALV_MS0       19'h00064
`define LACP_ALV_MS1       19'h000C8
`define LACP_ALV_MS2       19'h001F4
`define LACP_ALV_MS3       19'h003E8
`define LACP_ALV_MS4       19'h00BB8
`define LACP_ALV_MS5       19'h01388
`define LACP_ALV_MS6       19'h02710
`define LACP_ALV_MS7       19'h03A98

// Resumption timeout table, in ms
`define LACP_RES_MS0       19'h00000
`define LACP_RES_MS1       19'h01388
`define LACP_RES_MS2       19'h02710
`define LACP_RES_MS3       19'h03A98
`define LACP_RES_MS4       19'h07530
`define LACP_RES_MS5       19'h0EA60
`define LACP_RES_MS6       19'h1D4C0
`define LACP_RES_MS7       19'h493E0

`endif

// ---- core/lacp_tick.v ----
// Purpose: Millisecond tick divider for the negotiated timers
// Assumes: One clock domain
// Notes:   Emits a one-cycle enable every TICK_CYC cycles
`timescale 1ns/10ps
`default_nettype none

module lacp_tick #(
	parameter [13:0] TICK_CYC = 14'h2710
) (
	// Clock and reset
	input  wire       clk_sys,
	input  wire       rstn,
	// Tick enable
	output reg        tick
);

	reg [13:0] divCnt_ff;

	// Count up and pulse at wrap
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			divCnt_ff <= 14'h0000;
			tick      <= 1'b0;
		end else if (divCnt_ff >= TICK_CYC - 14'h0001) begin
			divCnt_ff <= 14'h0000;
			tick      <= 1'b1;
		end else begin
			divCnt_ff <= divCnt_ff + 14'h0001;
			tick      <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// ---- core/lacp_core.v ----
// Purpose: Login access control policy for one logical unit
// Assumes: Request strobes come from logic on clk_sys
// Notes:   One descriptor, its rules listed below
// Behaviour
// - Resumption timeout capped at five minutes
// - Keep owner context during resumption window
// - Keyed login stops and resets resumption timer
// - Resumption expiry releases access, logs out
// - Explicit logout releases resources at once
// - Ping sends unsolicited status with link state
// - No credit after ping: invalidate login
// - No credit: wait one interval, then logout
// - Payload minimum negotiated per direction
// - Payload in 128-byte units, limited
// - Descriptor holds owner, key, parameters
// - Power reset clears owner to ones
// - Owner cleared after release plus second
// - Same owner, wrong key: reject
// - Same owner, other parameters: reject
// - Reset service only for new owner
// - Fresh owner key each validated session
// - Release timeout is minimum of both
// - Inactivity timeout is minimum of both
// - Response returns key, timeouts, payloads
// - Alive code selects 100 ms to 15 s
// - Resumption code selects 0 s to 300 s
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "lacp_regs.vh"

module lacp_core #(
	parameter [13:0] TICK_CYC = `LACP_TICK_CYC
) (
	// Clock and reset
	input  wire        clk_sys,
	input  wire        rstn,
	// Register port
	input  wire [7:0]  regAddr,
	input  wire [31:0] regWdata,
	input  wire        regWr,
	input  wire        regRd,
	output reg  [31:0] regRdata,
	// Login request
	input  wire        loginReq,
	input  wire [63:0] reqUid,
	input  wire [31:0] reqKey,
	input  wire [2:0]  reqResume,
	input  wire [2:0]  reqAlive,
	input  wire [13:0] reqPayI2T,
	input  wire [13:0] reqPayT2I,
	// Session events
	input  wire        logoutReq,
	input  wire        implicitLogout,
	input  wire        initActivity,
	input  wire        creditGrant,
	// Login answer
	output reg         loginAccept,
	output reg         loginReject,
	output reg         serviceReset,
	// Descriptor and response values
	output reg  [63:0] ownerUid,
	output reg  [31:0] ownerKey,
	output reg  [2:0]  rspResume,
	output reg  [2:0]  rspAlive,
	output reg  [13:0] rspPayI2T,
	output reg  [13:0] rspPayT2I,
	// Session state and actions
	output reg         sessionActive,
	output reg         resumeHold,
	output reg         forceLogout,
	output reg         pingReq,
	output reg  [3:0]  pingStatus
);

	////////////////////////////////////////////////////////////////////////
	// Helper functions

	// Smaller of two codes
	function [2:0] minCode;
		input [2:0] a;
		input [2:0] b;
		begin
			minCode = (a < b) ? a : b;
		end
	endfunction

	// Smaller of request, support and absolute limit
	function [13:0] minPay;
		input [13:0] a;
		input [13:0] b;
		reg   [13:0] m;
		begin
			m = (a < b) ? a : b;
			minPay = (m > `LACP_PAY_LIMIT) ? `LACP_PAY_LIMIT : m;
		end
	endfunction

	// Alive code to ms
	function [18:0] aliveMs;
		input [2:0] c;
		begin
			case (c)
				3'h0: aliveMs = `LACP_ALV_MS0;
				3'h1: aliveMs = `LACP_ALV_MS1;
				3'h2: aliveMs = `LACP_ALV_MS2;
				3'h3: aliveMs = `LACP_ALV_MS3;
				3'h4: aliveMs = `LACP_ALV_MS4;
				3'h5: aliveMs = `LACP_ALV_MS5;
				3'h6: aliveMs = `LACP_ALV_MS6;
				default: aliveMs = `LACP_ALV_MS7;
			endcase
		end
	endfunction

	// Resumption code to ms, top code is five minutes
	function [18:0] resumeMs;
		input [2:0] c;
		begin
			case (c)
				3'h0: resumeMs = `LACP_RES_MS0;
				3'h1: resumeMs = `LACP_RES_MS1;
				3'h2: resumeMs = `LACP_RES_MS2;
				3'h3: resumeMs = `LACP_RES_MS3;
				3'h4: resumeMs = `LACP_RES_MS4;
				3'h5: resumeMs = `LACP_RES_MS5;
				3'h6: resumeMs = `LACP_RES_MS6;
				default: resumeMs = `LACP_RES_MS7;
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// State

	reg  [2:0]  appResume_ff;
	reg  [2:0]  appAlive_ff;
	reg  [13:0] payMaxI2T_ff;
	reg  [13:0] payMaxT2I_ff;
	reg         clearRun_ff;
	reg  [18:0] rsCnt_ff;
	reg  [18:0] aliveCnt_ff;
	reg         credit_ff;
	reg         strike_ff;
	reg  [31:0] lfsr_ff;
	wire        tick;

	// Millisecond time base
	lacp_tick #(
		.TICK_CYC (TICK_CYC)
	) uTick (
		.clk_sys  (clk_sys),
		.rstn     (rstn),
		.tick     (tick)
	);

	////////////////////////////////////////////////////////////////////////
	// Login validation

	// Negotiated values for this request
	wire [2:0]  nxt_resume = minCode(reqResume, appResume_ff);
	wire [2:0]  nxt_alive  = minCode(reqAlive, appAlive_ff);
	wire [13:0] nxt_payI2T = minPay(reqPayI2T, payMaxI2T_ff);
	wire [13:0] nxt_payT2I = minPay(reqPayT2I, payMaxT2I_ff);

	// Owner comparisons
	wire ownerValid = (ownerUid != `LACP_NO_OWNER);
	wire ownerMatch = (ownerUid == reqUid);
	wire negDiffer  = ({nxt_resume, nxt_alive, nxt_payI2T, nxt_payT2I} !=
		{rspResume, rspAlive, rspPayI2T, rspPayT2I});
	wire keyBad     = ownerValid & ownerMatch & (reqKey != ownerKey);
	wire negBad     = ownerValid & ownerMatch & negDiffer;
	wire busy       = ownerValid & ~ownerMatch & (sessionActive | resumeHold);
	wire loginOk    = loginReq & ~logoutReq & ~(keyBad | negBad | busy);
	wire loginBad   = loginReq & ~logoutReq & ~loginOk;

	// Fresh key, never zero and never the previous one
	wire [31:0] nxt_key = (lfsr_ff == ownerKey) ? ~lfsr_ff : lfsr_ff;

	////////////////////////////////////////////////////////////////////////
	// Timer events

	wire aliveExp  = sessionActive & tick & (aliveCnt_ff <= 19'h00001);
	wire rsExp     = tick & (rsCnt_ff <= 19'h00001);
	wire resumeExp = resumeHold & rsExp;
	wire clearExp  = clearRun_ff & rsExp;
	wire doPing    = aliveExp & credit_ff;
	wire aliveOut  = aliveExp & ~credit_ff & strike_ff;
	wire implOk    = implicitLogout & sessionActive & ~logoutReq & ~loginReq;

	////////////////////////////////////////////////////////////////////////
	// Register port

	// Software configuration of application maxima
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			appResume_ff <= `LACP_RST_APPRES;
			appAlive_ff  <= `LACP_RST_APPALV;
			payMaxI2T_ff <= `LACP_RST_PAYMAX;
			payMaxT2I_ff <= `LACP_RST_PAYMAX;
		end else if (regWr) begin
			if (regAddr == `LACP_REG_CTRL) begin
				appResume_ff <= regWdata[`LACP_CTRL_RES_LSB +: 3];
				appAlive_ff  <= regWdata[`LACP_CTRL_ALV_LSB +: 3];
			end
			if (regAddr == `LACP_REG_PAYI2T)
				payMaxI2T_ff <= regWdata[13:0];
			if (regAddr == `LACP_REG_PAYT2I)
				payMaxT2I_ff <= regWdata[13:0];
		end
	end

	// Read data one cycle after the strobe, zero otherwise
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			regRdata <= 32'h00000000;
		end else if (regRd) begin
			case (regAddr)
				`LACP_REG_CTRL: regRdata <= {25'h0000000, appAlive_ff, 1'b0, appResume_ff};
				`LACP_REG_PAYI2T: regRdata <= {18'h00000, payMaxI2T_ff};
				`LACP_REG_PAYT2I: regRdata <= {18'h00000, payMaxT2I_ff};
				`LACP_REG_STATUS: regRdata <= {26'h0000000, strike_ff, credit_ff,
					ownerValid, clearRun_ff, resumeHold, sessionActive};
				`LACP_REG_OWNLO: regRdata <= ownerUid[31:0];
				`LACP_REG_OWNHI: regRdata <= ownerUid[63:32];
				`LACP_REG_KEY: regRdata <= ownerKey;
				`LACP_REG_NEG: regRdata <= {25'h0000000, rspAlive, 1'b0, rspResume};
				`LACP_REG_NEGPAY: regRdata <= {2'h0, rspPayT2I, 2'h0, rspPayI2T};
				default: regRdata <= 32'h00000000;
			endcase
		end else begin
			regRdata <= 32'h00000000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Key generator

	// Free running LFSR, never reaches zero
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			lfsr_ff <= `LACP_KEY_SEED;
		else if (lfsr_ff[0])
			lfsr_ff <= (lfsr_ff >> 1) ^ `LACP_LFSR_TAPS;
		else
			lfsr_ff <= lfsr_ff >> 1;
	end

	////////////////////////////////////////////////////////////////////////
	// Access control descriptor

	// Owner, key and negotiated parameters
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ownerUid  <= `LACP_NO_OWNER;
			ownerKey  <= 32'h00000000;
			rspResume <= 3'h0;
			rspAlive  <= 3'h0;
			rspPayI2T <= 14'h0000;
			rspPayT2I <= 14'h0000;
		end else if (logoutReq) begin
			ownerUid  <= `LACP_NO_OWNER;
			ownerKey  <= 32'h00000000;
		end else if (loginOk) begin
			ownerUid  <= reqUid;
			ownerKey  <= nxt_key;
			rspResume <= nxt_resume;
			rspAlive  <= nxt_alive;
			rspPayI2T <= nxt_payI2T;
			rspPayT2I <= nxt_payT2I;
		end else if (clearExp) begin
			ownerUid  <= `LACP_NO_OWNER;
		end
	end

	// Login answer pulses
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			loginAccept  <= 1'b0;
			loginReject  <= 1'b0;
			serviceReset <= 1'b0;
		end else begin
			loginAccept  <= loginOk;
			loginReject  <= loginBad;
			serviceReset <= loginOk & ~ownerMatch;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Session and resumption timer

	// Resumption window, then owner clear delay, on one counter
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			sessionActive <= 1'b0;
			resumeHold    <= 1'b0;
			clearRun_ff   <= 1'b0;
			rsCnt_ff      <= 19'h00000;
		end else if (logoutReq) begin
			sessionActive <= 1'b0;
			resumeHold    <= 1'b0;
			clearRun_ff   <= 1'b0;
			rsCnt_ff      <= 19'h00000;
		end else if (loginOk) begin
			sessionActive <= 1'b1;
			resumeHold    <= 1'b0;
			clearRun_ff   <= 1'b0;
			rsCnt_ff      <= 19'h00000;
		end else if (implOk) begin
			sessionActive <= 1'b0;
			resumeHold    <= 1'b1;
			rsCnt_ff      <= resumeMs(rspResume);
		end else if (aliveOut) begin
			sessionActive <= 1'b0;
		end else if (resumeExp) begin
			resumeHold    <= 1'b0;
			clearRun_ff   <= 1'b1;
			rsCnt_ff      <= `LACP_CLEAR_MS;
		end else if (clearExp) begin
			clearRun_ff   <= 1'b0;
			rsCnt_ff      <= 19'h00000;
		end else if (tick & (resumeHold | clearRun_ff)) begin
			rsCnt_ff      <= rsCnt_ff - 19'h00001;
		end
	end

	// Implicit logout of unreconnected logins and alive failures
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			forceLogout <= 1'b0;
		else
			forceLogout <= ~logoutReq & ~loginOk & ~implOk & (aliveOut | resumeExp);
	end

	////////////////////////////////////////////////////////////////////////
	// Transport alive supervision

	// Credit flag: a grant wins over a same-cycle consume
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			credit_ff <= 1'b0;
		else
			credit_ff <= creditGrant | (credit_ff & ~doPing & ~loginOk);
	end

	// Strike: set by any expired interval, with or without credit, cleared by credit
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			strike_ff <= 1'b0;
		else if (creditGrant | loginOk | ~sessionActive)
			strike_ff <= 1'b0;
		else if (aliveExp)
			strike_ff <= 1'b1;
	end

	// Inactivity counter, restarted by activity or credit
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			aliveCnt_ff <= 19'h00000;
		else if (loginOk)
			aliveCnt_ff <= aliveMs(nxt_alive);
		else if (initActivity | creditGrant | aliveExp)
			aliveCnt_ff <= aliveMs(rspAlive);
		else if (tick & sessionActive)
			aliveCnt_ff <= aliveCnt_ff - 19'h00001;
	end

	// Unsolicited status ping with current communication state
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pingReq    <= 1'b0;
			pingStatus <= 4'h0;
		end else begin
			pingReq    <= doPing & ~logoutReq & ~loginReq;
			if (doPing)
				pingStatus <= {strike_ff, ownerValid, resumeHold, sessionActive};
		end
	end
endmodule

`default_nettype wire

// ---- dv/lacp_core_monitor.sv ----
// Purpose: Port-level checker for the login access control block
// Assumes: Single clock domain, asynchronous active-low reset
// Notes:   Bound to every lacp_core instance
`timescale 1ns/10ps
`default_nettype none

module lacp_core_monitor (
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        rstn,
	// Requests
	input wire logic        loginReq,
	input wire logic        logoutReq,
	input wire logic        implicitLogout,
	// Answers and state
	input wire logic        loginAccept,
	input wire logic        loginReject,
	input wire logic        serviceReset,
	input wire logic [63:0] ownerUid,
	input wire logic        sessionActive,
	input wire logic        resumeHold,
	input wire logic        forceLogout,
	input wire logic        pingReq
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	////////////////////////////////////////////////////////////////////////
	// Multi-step behaviours
	sequence sImplicit;
		implicitLogout && sessionActive && !loginReq && !logoutReq;
	endsequence
	sequence sHold;
		resumeHold && !sessionActive && $stable(ownerUid);
	endsequence
	sequence sLogin;
		loginReq && !logoutReq;
	endsequence

	////////////////////////////////////////////////////////////////////////
	// Assertions
	AST_LOGOUT_CLEARS: assert property (logoutReq |=> !sessionActive && !resumeHold
		&& ownerUid == 64'hFFFFFFFFFFFFFFFF) else $error("logout left owner or session");
	AST_LOGIN_ANSWER: assert property (sLogin |=> loginAccept ^ loginReject)
		else $error("login got no single answer");
	AST_SVC_RESET_NEW: assert property (loginAccept |->
		serviceReset == (ownerUid != $past(ownerUid))) else $error("service reset wrong");
	AST_ACCEPT_ACTIVE: assert property (loginAccept |-> sessionActive && !resumeHold)
		else $error("accepted login not active");
	AST_FORCE_DROPS: assert property (forceLogout |-> !sessionActive && !resumeHold)
		else $error("forced logout kept session");
	AST_IMPLICIT_HOLD: assert property (sImplicit |=> sHold)
		else $error("implicit logout lost context");
	AST_REJECT_KEEPS: assert property (loginReject |-> $stable(ownerUid))
		else $error("rejected login changed owner");
	AST_PING_ACTIVE: assert property (pingReq |-> sessionActive)
		else $error("ping outside session");
	AST_OWNER_DELAY: assert property (forceLogout && !loginReq && !logoutReq
		|=> $stable(ownerUid)[*2]) else $error("owner cleared too early");
endmodule

bind lacp_core lacp_core_monitor lacp_core_monitor_inst (.*);
`default_nettype wire

// ---- dv/lacp_host_model.sv ----
// Purpose: Host initiator model issuing login and session events
// Assumes: Tasks are entered just after a rising clock edge
// Notes:   Released request fields show inverted values
`timescale 1ns/10ps
`default_nettype none

module lacp_host_model (
	// Clock
	input wire logic         clk_sys,
	// Login request
	output logic             loginReq,
	output logic      [63:0] reqUid,
	output logic      [31:0] reqKey,
	output logic      [2:0]  reqResume,
	output logic      [2:0]  reqAlive,
	output logic      [13:0] reqPayI2T,
	output logic      [13:0] reqPayT2I,
	// Session events
	output logic      [3:0]  evt
);
	initial begin
		loginReq = 1'b0;
		{reqUid, reqKey, reqResume, reqAlive, reqPayI2T, reqPayT2I} = '0;
		evt = 4'h0;
	end

	// Login first, codes kept in their 3-bit tables, payload in 128-byte units
	task automatic login(input logic [63:0] u, input logic [31:0] k,
		input logic [2:0] r, input logic [2:0] a, input logic [13:0] pi, input logic [13:0] pt);
		@(posedge clk_sys);
		loginReq <= 1'b1;
		{reqUid, reqKey, reqResume, reqAlive, reqPayI2T, reqPayT2I} <= {u, k, r, a, pi, pt};
		@(posedge clk_sys);
		loginReq <= 1'b0;
		{reqUid, reqKey, reqResume, reqAlive, reqPayI2T, reqPayT2I} <= ~{u, k, r, a, pi, pt};
		#1;
	endtask

	// One-cycle event: 0 logout, 1 implicit, 2 activity, 3 credit
	task automatic pulse(input int s);
		@(posedge clk_sys);
		evt[s] <= 1'b1;
		@(posedge clk_sys);
		evt[s] <= 1'b0;
		#1;
	endtask
endmodule
`default_nettype wire

// ---- dv/lacp_core_tb_top.sv ----
// Purpose: Self-checking bench for the login access control block
// Assumes: Tick shortened to 4 clocks per millisecond
// Notes:   Alive code 0 and resume code 1 keep the run short
`timescale 1ns/10ps
`default_nettype none

module lacp_core_tb_top;
	localparam logic [63:0] NONE = 64'hFFFFFFFFFFFFFFFF;
	logic clk_sys, rstn, regWr, regRd, loginReq, serviceReset, loginAccept, loginReject;
	logic sessionActive, resumeHold, forceLogout, pingReq;
	logic [7:0] regAddr;
	logic [31:0] regWdata, regRdata, reqKey, ownerKey, k1;
	logic [63:0] reqUid, ownerUid;
	logic [2:0] reqResume, reqAlive, rspResume, rspAlive;
	logic [13:0] reqPayI2T, reqPayT2I, rspPayI2T, rspPayT2I;
	logic [3:0] evt, pingStatus;
	int miscompares, totalChecks, n;

	lacp_host_model lacp_host_model_inst (.clk_sys(clk_sys), .loginReq(loginReq),
		.reqUid(reqUid), .reqKey(reqKey), .reqResume(reqResume), .reqAlive(reqAlive),
		.reqPayI2T(reqPayI2T), .reqPayT2I(reqPayT2I), .evt(evt));

	lacp_core #(.TICK_CYC(14'h0004)) lacp_core_inst (.clk_sys(clk_sys), .rstn(rstn),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .loginReq(loginReq), .reqUid(reqUid), .reqKey(reqKey),
		.reqResume(reqResume), .reqAlive(reqAlive), .reqPayI2T(reqPayI2T),
		.reqPayT2I(reqPayT2I), .logoutReq(evt[0]), .implicitLogout(evt[1]),
		.initActivity(evt[2]), .creditGrant(evt[3]), .loginAccept(loginAccept),
		.loginReject(loginReject), .serviceReset(serviceReset), .ownerUid(ownerUid),
		.ownerKey(ownerKey), .rspResume(rspResume), .rspAlive(rspAlive),
		.rspPayI2T(rspPayI2T), .rspPayT2I(rspPayT2I), .sessionActive(sessionActive),
		.resumeHold(resumeHold), .forceLogout(forceLogout), .pingReq(pingReq),
		.pingStatus(pingStatus));

	////////////////////////////////////////////////////////////////////////
	// Clock, compare, verdict
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		totalChecks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic finishTest();
		$display("Checks %0d, mismatches %0d", totalChecks, miscompares);
		if (miscompares == 0 && totalChecks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	// Bounded wait: 0 forced logout, 1 ping, 2 owner cleared
	task automatic waitSig(input int s, input int lim, output int c);
		c = 0;
		do begin
			@(posedge clk_sys);
			#1;
			c++;
		end while (!(s == 0 ? forceLogout : s == 1 ? pingReq : ownerUid === NONE) && c < lim);
		if (c >= lim) begin
			miscompares++;
			finishTest();
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// Register port
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		{regWr, regAddr, regWdata} <= {1'b1, a, d};
		@(posedge clk_sys);
		regWr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		{regRd, regAddr} <= {1'b1, a};
		@(posedge clk_sys);
		regRd <= 1'b0;
		#1;
		chk(regRdata, e);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic tReset();
		chk(ownerUid, NONE);
		rd(8'h00, 32'h00000077);
		rd(8'h04, 32'h00002000);
		rd(8'h24, 32'h00000000);
		wr(8'h00, 32'h00000001);
		wr(8'h08, 32'h00000100);
		rd(8'h00, 32'h00000001);
		rd(8'h08, 32'h00000100);
	endtask

	task automatic tNewLogin();
		lacp_host_model_inst.login(64'h0123456789ABCDEF, 32'h0, 3'h7, 3'h7, 14'h3FFF, 14'h0180);
		chk({loginAccept, serviceReset, sessionActive}, 3'h7);
		chk(ownerUid, 64'h0123456789ABCDEF);
		chk({rspResume, rspAlive}, 6'h08);
		chk({rspPayI2T, rspPayT2I}, {14'h2000, 14'h0100});
		rd(8'h20, 32'h01002000);
		k1 = ownerKey;
	endtask

	task automatic tKeys();
		lacp_host_model_inst.login(64'h0123456789ABCDEF, ~k1, 3'h1, 3'h0, 14'h2000, 14'h0100);
		chk(loginReject, 1'b1);
		lacp_host_model_inst.login(64'h0123456789ABCDEF, k1, 3'h0, 3'h0, 14'h2000, 14'h0100);
		chk(loginReject, 1'b1);
		lacp_host_model_inst.login(64'h0123456789ABCDEF, k1, 3'h1, 3'h0, 14'h2000, 14'h0100);
		chk({loginAccept, serviceReset}, 2'b10);
		chk(ownerKey !== k1, 1'b1);
	endtask

	task automatic tResume();
		lacp_host_model_inst.pulse(1);
		chk({resumeHold, sessionActive}, 2'b10);
		lacp_host_model_inst.login(64'h0123456789ABCDEF, ownerKey, 3'h1, 3'h0, 14'h2000, 14'h0100);
		chk({loginAccept, resumeHold}, 2'b10);
		lacp_host_model_inst.pulse(1);
		waitSig(0, 21000, n);
		chk(n >= 19900, 1'b1);
		chk(ownerUid, 64'h0123456789ABCDEF);
		waitSig(2, 4200, n);
		chk(n >= 3990, 1'b1);
	endtask

	// Ping, then no credit: logout one interval later; no credit at all: two
	task automatic tAlive();
		lacp_host_model_inst.login(64'h00000000000000A5, 32'h0, 3'h1, 3'h0, 14'h2000, 14'h0100);
		chk({loginAccept, serviceReset}, 2'b11);
		lacp_host_model_inst.pulse(2);
		lacp_host_model_inst.pulse(3);
		waitSig(1, 500, n);
		chk(pingStatus, 4'h5);
		waitSig(0, 450, n);
		chk(n >= 390, 1'b1);
		chk(sessionActive, 1'b0);
		chk(ownerUid, 64'h00000000000000A5);
		lacp_host_model_inst.login(64'h00000000000000A5, ownerKey, 3'h1, 3'h0, 14'h2000, 14'h0100);
		chk({loginAccept, serviceReset}, 2'b10);
		waitSig(0, 900, n);
		chk(n >= 790, 1'b1);
		chk(sessionActive, 1'b0);
	endtask

	task automatic tLogout();
		lacp_host_model_inst.login(64'h00000000000000A5, ownerKey, 3'h1, 3'h0, 14'h2000, 14'h0100);
		chk(loginAccept, 1'b1);
		lacp_host_model_inst.pulse(0);
		chk(sessionActive, 1'b0);
		chk(ownerUid, NONE);
		chk(ownerKey, 32'h0);
	endtask

	// Power reset in mid-run drops the owner and restores the timeout code maxima
	task automatic tPowerReset();
		lacp_host_model_inst.login(64'h0000000000005A5A, 32'h0, 3'h1, 3'h0, 14'h2000, 14'h0100);
		chk(ownerUid, 64'h0000000000005A5A);
		@(posedge clk_sys);
		rstn <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk(ownerUid, NONE);
		chk(sessionActive, 1'b0);
		rstn <= 1'b1;
		rd(8'h00, 32'h00000077);
		chk(ownerUid, NONE);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{rstn, regWr, regRd, regAddr, regWdata} = '0;
		miscompares = 0;
		totalChecks = 0;
		repeat (16) @(posedge clk_sys);
		rstn <= 1'b1;
		tReset();
		tNewLogin();
		tKeys();
		tResume();
		tAlive();
		tLogout();
		tPowerReset();
		finishTest();
	end
endmodule
`default_nettype wire
